// ---- pscr_map.svh ----
// register offsets, chain field positions, reset values and timing for the pll scan chain block
`ifndef PSCR_MAP_SVH
`define PSCR_MAP_SVH

// ============================================================
// chain segment layout
`define PSCR_SEG_W       18
`define PSCR_CNT_W       8
`define PSCR_LOW_LSB     0
`define PSCR_HIGH_LSB    8
`define PSCR_BYP_BIT     16
`define PSCR_ODD_BIT     17
`define PSCR_SEG_RESET   18'h1_0000
`define PSCR_TAIL_RESET  18'h0_0000

// ============================================================
// chain tail layout (charge pump, post-vco divider, spare, loop filter)
`define PSCR_CP_LSB      0
`define PSCR_CP_W        3
`define PSCR_K_BIT       3
`define PSCR_SPARE_LSB   4
`define PSCR_SPARE_W     7
`define PSCR_LFC_LSB     11
`define PSCR_LFC_W       2
`define PSCR_LFR_LSB     13
`define PSCR_LFR_W       5

// ============================================================
// register map (byte addresses)
`define PSCR_CTRL_OFS    8'h00
`define PSCR_STATUS_OFS  8'h04
`define PSCR_SEL_OFS     8'h08
`define PSCR_SETTING_OFS 8'h0C
`define PSCR_LOOPM_OFS   8'h10
`define PSCR_LOOPN_OFS   8'h14
`define PSCR_TAIL_OFS    8'h18
`define PSCR_CTRL_WIDE_BIT 0
`define PSCR_CTRL_HALF_LSB 8
`define PSCR_HALF_RESET  8'h01
`define PSCR_RESP_OKAY   2'h0
`define PSCR_RESP_SLVERR 2'h2

// ============================================================
// timing
`define PSCR_ACLK_NS     4
`define PSCR_SCLK_MIN_NS 10
`define PSCR_SCLK_MIN_CYC ((`PSCR_SCLK_MIN_NS + `PSCR_ACLK_NS - 1) / `PSCR_ACLK_NS)
`define PSCR_CNT_RESET   11'h7FF

`endif

// ---- pscr_pkg.sv ----
// types shared by the pll scan chain block
package pscr_pkg;
`include "pscr_map.svh"

	// one 18-bit chain segment: low count, high count, bypass, odd select
	typedef logic [`PSCR_SEG_W-1:0] pscr_seg_type;

	// reconfiguration progress
	typedef enum logic {PSCR_IDLE, PSCR_APPLY} pscr_phase_type;
endpackage

// ---- pscr_post_counter.sv ----
// one post-scale output counter running on half-cycle ticks of the emulated vco
module pscr_post_counter
	import pscr_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 half_tick,
	input  wire logic                 vco_level,
	input  wire pscr_pkg::pscr_seg_type new_cfg,
	input  wire logic                 load_req,
	output pscr_pkg::pscr_seg_type    cfg_out,
	output logic                      clk_out,
	output logic                      loaded
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ============================================================
	// period arithmetic in half vco cycles
	pscr_seg_type cfg_reg;
	logic [10:0]  cnt_reg;
	logic         clk_out_reg;
	logic         loaded_reg;
	wire  [8:0]   hi_cnt    = (cfg_reg[`PSCR_HIGH_LSB +: `PSCR_CNT_W] == 8'h00) ? 9'h100
	                          : {1'b0, cfg_reg[`PSCR_HIGH_LSB +: `PSCR_CNT_W]};
	wire  [8:0]   lo_cnt    = (cfg_reg[`PSCR_LOW_LSB +: `PSCR_CNT_W] == 8'h00) ? 9'h100
	                          : {1'b0, cfg_reg[`PSCR_LOW_LSB +: `PSCR_CNT_W]};
	wire          bypass    = cfg_reg[`PSCR_BYP_BIT];
	wire          odd_sel   = cfg_reg[`PSCR_ODD_BIT];
	wire  [9:0]   sum_cnt   = {1'b0, hi_cnt} + {1'b0, lo_cnt};
	wire  [10:0]  period_h  = bypass ? 11'h002 : {sum_cnt, 1'b0};
	wire  [10:0]  high_h    = {1'b0, hi_cnt, 1'b0} - {10'h000, odd_sel};
	wire          wrap      = ~vco_level & (cnt_reg >= period_h - 11'h001);
	wire  [10:0]  cnt_inc   = cnt_reg + 11'h001;
	wire          out_next  = wrap ? 1'b1 : (bypass ? ~vco_level : (cnt_inc < high_h));
	wire          take_new  = half_tick & wrap & load_req;

	// ============================================================
	// new setting taken only at a period boundary on this counter's own clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg     <= `PSCR_SEG_RESET;
			cnt_reg     <= `PSCR_CNT_RESET;
			clk_out_reg <= 1'b0;
			loaded_reg  <= 1'b0;
		end else begin
			loaded_reg <= take_new;
			if (take_new) begin
				cfg_reg <= new_cfg;
			end
			if (half_tick) begin
				cnt_reg     <= wrap ? 11'h000 : cnt_inc;
				clk_out_reg <= out_next;
			end
		end
	end

	assign cfg_out = cfg_reg;
	assign clk_out = clk_out_reg;
	assign loaded  = loaded_reg;

	// ============================================================
	// checks
	a_bypass_follows: assert property ((half_tick && bypass) |=> (clk_out_reg == vco_level))
		else $error("bypassed counter does not follow the vco");
	a_high_end: assert property ((half_tick && !bypass && !wrap && cnt_inc == high_h)
		|=> (!clk_out_reg && (vco_level == !$past(odd_sel))))
		else $error("high phase ends on the wrong vco edge");
	a_load_boundary: assert property (loaded_reg |-> (clk_out_reg && vco_level && cnt_reg == 11'h000))
		else $error("setting taken away from a period boundary");
endmodule

// ---- pscr_top.sv ----
// pll scan chain reconfiguration: serial chain, update, post-scale counters and register slave
//
// Behaviour
// - chain moves one bit per shift-clock rise only while shift enable is high
// - update strobe after last bit copies chain into the active configuration
// - each counter takes its new setting on its own period boundary
// - first data bit enters on the second shift-clock rise after enable
// - progress flag high while applying, falls once all counters hold settings
// - shift, update and completion may repeat any number of times
// - chain holds pre-scale, feedback, post-vco, seven or ten outputs, pump, filter
// - each output counter has 8-bit high and 8-bit low counts
// - duty cycle is high or low count over their sum
// - bypass set divides by one, clear divides by high plus low
// - odd select clear: output falls on a rising vco edge
// - odd select set: output falls on a falling vco edge, half cycle shift
// - each counter segment is 16 count bits plus bypass and odd bits
// - first bit is low-count lsb of highest counter, last is filter msb
// - tail holds 3 pump, 1 divider, 2 capacitor, 5 resistor, 7 spare bits
module pscr_top
	import pscr_pkg::*;
#(
	parameter int NUM_OUT    = 10,
	parameter int NARROW_OUT = 7,
	parameter int CHAIN_MAX  = 234,
	parameter int ADDR_W     = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              chain_shift_clock,
	input  wire logic              chain_shift_enable,
	input  wire logic              chain_serial_in_port,
	input  wire logic              apply_settings_strobe,
	output logic                   reconfig_in_progress,
	output logic [NUM_OUT-1:0]     divider_clk_out,
	output pscr_pkg::pscr_seg_type loop_m_setting,
	output pscr_pkg::pscr_seg_type loop_n_setting,
	output pscr_pkg::pscr_seg_type loop_tail_setting
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// segment at a given position counted from the first bit shifted in
	function automatic pscr_seg_type seg_at(input logic [CHAIN_MAX-1:0] c, input int idx);
		return c[idx*`PSCR_SEG_W +: `PSCR_SEG_W];
	endfunction

	// ============================================================
	// shift clock edge detection and chain shifting
	logic                 sclk_prev_reg;
	logic                 armed_reg;
	logic                 strobe_seen_reg;
	logic [CHAIN_MAX-1:0] chain_reg;
	logic [CHAIN_MAX-1:0] chain_next;
	logic                 ctrl_wide_reg;
	wire                  sclk_rise  = chain_shift_clock & ~sclk_prev_reg;
	wire                  shift_now  = sclk_rise & chain_shift_enable & armed_reg;
	wire                  upd_now    = sclk_rise & apply_settings_strobe & ~strobe_seen_reg;
	wire integer          n_active   = ctrl_wide_reg ? NUM_OUT : NARROW_OUT;
	wire integer          chain_len  = (n_active + 3) * `PSCR_SEG_W;

	// new bit enters at the far end so the first bit lands at position zero
	always_comb begin
		chain_next = chain_reg;
		if (shift_now) begin
			chain_next                = {1'b0, chain_reg[CHAIN_MAX-1:1]};
			chain_next[chain_len - 1] = chain_serial_in_port;
		end
	end

	// first rise with enable high only arms the chain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_prev_reg   <= 1'b0;
			armed_reg       <= 1'b0;
			strobe_seen_reg <= 1'b0;
			chain_reg       <= '0;
		end else begin
			sclk_prev_reg <= chain_shift_clock;
			armed_reg     <= chain_shift_enable & (armed_reg | sclk_rise);
			if (sclk_rise) begin
				strobe_seen_reg <= apply_settings_strobe;
			end
			chain_reg <= chain_next;
		end
	end

	// ============================================================
	// update: stage settings for each active counter, load loop settings at once
	pscr_seg_type   stage_reg [NUM_OUT];
	pscr_seg_type   cfg_view  [NUM_OUT];
	logic [NUM_OUT-1:0] pending_reg;
	logic [NUM_OUT-1:0] loaded;
	logic [NUM_OUT-1:0] upd_mask;
	pscr_phase_type phase_reg;
	pscr_seg_type   loop_m_reg;
	pscr_seg_type   loop_n_reg;
	pscr_seg_type   loop_tail_reg;
	wire pscr_seg_type m_from_chain    = seg_at(chain_reg, n_active);
	wire pscr_seg_type n_from_chain    = seg_at(chain_reg, n_active + 1);
	wire pscr_seg_type tail_from_chain = seg_at(chain_reg, n_active + 2);

	// counters live in the low segments, highest counter first
	always_comb begin
		for (int k = 0; k < NUM_OUT; k++) begin
			upd_mask[k] = (k < n_active);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < NUM_OUT; k++) begin
				stage_reg[k] <= `PSCR_SEG_RESET;
			end
		end else if (upd_now) begin
			for (int k = 0; k < NUM_OUT; k++) begin
				if (k < n_active) begin
					stage_reg[k] <= seg_at(chain_reg, n_active - 1 - k);
				end
			end
		end
	end

	// loop settings change only on an update; a new update wins over completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pending_reg   <= '0;
			phase_reg     <= PSCR_IDLE;
			loop_m_reg    <= `PSCR_SEG_RESET;
			loop_n_reg    <= `PSCR_SEG_RESET;
			loop_tail_reg <= `PSCR_TAIL_RESET;
		end else begin
			pending_reg <= (pending_reg & ~loaded) | (upd_now ? upd_mask : '0);
			if (upd_now) begin
				loop_m_reg    <= m_from_chain;
				loop_n_reg    <= n_from_chain;
				loop_tail_reg <= tail_from_chain;
			end
			unique case (phase_reg)
				PSCR_IDLE: begin
					if (upd_now) begin
						phase_reg <= PSCR_APPLY;
					end
				end
				PSCR_APPLY: begin
					if (!upd_now && (pending_reg & ~loaded) == '0) begin
						phase_reg <= PSCR_IDLE;
					end
				end
			endcase
		end
	end

	assign reconfig_in_progress = (phase_reg == PSCR_APPLY);
	assign loop_m_setting       = loop_m_reg;
	assign loop_n_setting       = loop_n_reg;
	assign loop_tail_setting    = loop_tail_reg;

	// ============================================================
	// emulated vco: half-cycle tick every half_sel_reg+1 clocks
	logic [7:0] half_sel_reg;
	logic [7:0] half_cnt_reg;
	logic       vco_level_reg;
	wire        half_tick = (half_cnt_reg >= half_sel_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_cnt_reg  <= 8'h00;
			vco_level_reg <= 1'b0;
		end else begin
			half_cnt_reg  <= half_tick ? 8'h00 : half_cnt_reg + 8'h01;
			vco_level_reg <= vco_level_reg ^ half_tick;
		end
	end

	// one counter per output, each with its own load moment
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
		pscr_post_counter u_cnt (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.half_tick (half_tick),
			.vco_level (vco_level_reg),
			.new_cfg   (stage_reg[g]),
			.load_req  (pending_reg[g]),
			.cfg_out   (cfg_view[g]),
			.clk_out   (divider_clk_out[g]),
			.loaded    (loaded[g])
		);
	end

	// ============================================================
	// axi4-lite slave: one write and one read at a time
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic [3:0]        sel_reg;
	wire  aw_take = s_axi_awvalid & awready_reg;
	wire  w_take  = s_axi_wvalid & wready_reg;
	wire  wr_go   = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire  b_done  = bvalid_reg & s_axi_bready;
	wire  ar_take = s_axi_arvalid & arready_reg;
	wire  r_done  = rvalid_reg & s_axi_rready;
	wire  wr_ctrl = wr_go & (awaddr_reg == `PSCR_CTRL_OFS);
	wire  wr_sel  = wr_go & (awaddr_reg == `PSCR_SEL_OFS);

	// read decode
	wire pscr_seg_type sel_view = (sel_reg < NUM_OUT) ? cfg_view[sel_reg] : '0;
	wire [31:0] ctrl_word   = {16'h0000, half_sel_reg, 7'h00, ctrl_wide_reg};
	wire [31:0] status_word = 32'({pending_reg, reconfig_in_progress});
	wire        rd_ok = (s_axi_araddr == `PSCR_CTRL_OFS) | (s_axi_araddr == `PSCR_STATUS_OFS)
	                  | (s_axi_araddr == `PSCR_SEL_OFS) | (s_axi_araddr == `PSCR_SETTING_OFS)
	                  | (s_axi_araddr == `PSCR_LOOPM_OFS) | (s_axi_araddr == `PSCR_LOOPN_OFS)
	                  | (s_axi_araddr == `PSCR_TAIL_OFS);
	wire [31:0] rd_word =
		(s_axi_araddr == `PSCR_CTRL_OFS)    ? ctrl_word :
		(s_axi_araddr == `PSCR_STATUS_OFS)  ? status_word :
		(s_axi_araddr == `PSCR_SEL_OFS)     ? {28'h000_0000, sel_reg} :
		(s_axi_araddr == `PSCR_SETTING_OFS) ? {14'h0000, sel_view} :
		(s_axi_araddr == `PSCR_LOOPM_OFS)   ? {14'h0000, loop_m_reg} :
		(s_axi_araddr == `PSCR_LOOPN_OFS)   ? {14'h0000, loop_n_reg} :
		(s_axi_araddr == `PSCR_TAIL_OFS)    ? {14'h0000, loop_tail_reg} : 32'h0000_0000;

	// write channels: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `PSCR_RESP_OKAY;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end else begin
			if (aw_take) begin
				awaddr_reg  <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end else if (b_done) begin
				awready_reg <= 1'b1;
			end
			if (w_take) begin
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end else if (b_done) begin
				wready_reg <= 1'b1;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wr_ctrl | wr_sel) ? `PSCR_RESP_OKAY : `PSCR_RESP_SLVERR;
			end else if (b_done) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// writable control fields with byte-lane enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_wide_reg <= 1'b1;
			half_sel_reg  <= `PSCR_HALF_RESET;
			sel_reg       <= 4'h0;
		end else begin
			if (wr_ctrl && wstrb_reg[0]) begin
				ctrl_wide_reg <= wdata_reg[`PSCR_CTRL_WIDE_BIT];
			end
			if (wr_ctrl && wstrb_reg[1]) begin
				half_sel_reg <= wdata_reg[`PSCR_CTRL_HALF_LSB +: 8];
			end
			if (wr_sel && wstrb_reg[0]) begin
				sel_reg <= wdata_reg[3:0];
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `PSCR_RESP_OKAY;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_word;
			rresp_reg   <= rd_ok ? `PSCR_RESP_OKAY : `PSCR_RESP_SLVERR;
		end else if (r_done) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// ============================================================
	// checks
	sequence s_first_rise;
		chain_shift_enable && !armed_reg && sclk_rise;
	endsequence
	sequence s_later_rise;
		chain_shift_enable && armed_reg && sclk_rise;
	endsequence

	a_hold_no_enable: assert property ((sclk_rise && !chain_shift_enable) |=> $stable(chain_reg))
		else $error("chain moved without shift enable");
	a_first_rise: assert property (s_first_rise |=> ($stable(chain_reg) && armed_reg))
		else $error("chain moved on the first shift clock rise");
	a_later_capture: assert property (s_later_rise
		|=> (chain_reg[chain_len - 1] == $past(chain_serial_in_port)))
		else $error("serial bit not captured");
	a_update_copy: assert property (upd_now |=> (reconfig_in_progress && loop_m_reg == $past(m_from_chain)
		&& pending_reg == $past(upd_mask)))
		else $error("update did not copy the chain");
	a_done_falls: assert property ((reconfig_in_progress && !upd_now && (pending_reg & ~loaded) == '0)
		|=> !reconfig_in_progress)
		else $error("progress flag did not fall");
	a_active_held: assert property (!upd_now |=> ($stable(loop_m_reg) && $stable(loop_n_reg)
		&& $stable(loop_tail_reg)))
		else $error("active settings changed without update");
endmodule

// ---- pscr_ctl_model.sv ----
// reconfiguration controller model that drives the serial chain pins
module pscr_ctl_model (
	input  wire logic aclk,
	output logic      chain_shift_clock,
	output logic      chain_shift_enable,
	output logic      chain_serial_in_port,
	output logic      apply_settings_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// shift clock stands low outside frames
	initial begin
		chain_shift_clock = 1'b0;
		chain_shift_enable = 1'b0;
		chain_serial_in_port = 1'b0;
		apply_settings_strobe = 1'b0;
	end

	// one shift-clock cycle, three aclk per phase, about 42 MHz
	task automatic tick();
		repeat (3) @(posedge aclk);
		chain_shift_clock <= 1'b1;
		repeat (3) @(posedge aclk);
		chain_shift_clock <= 1'b0;
	endtask

	// arming rise, n bits first-bit-first, then two rises with enable low
	task automatic send(input logic [233:0] v, input int n);
		int i;
		chain_shift_enable <= 1'b1;
		chain_serial_in_port <= ~v[0]; // arming rise must not capture
		tick();
		for (i = 0; i < n; i++) begin
			chain_serial_in_port <= v[i];
			tick();
		end
		chain_shift_enable <= 1'b0;
		repeat (2) begin
			chain_serial_in_port <= ~chain_serial_in_port;
			tick();
		end
	endtask

	// update strobe held over one shift-clock rise
	// output phase offsets stay zero here, so no phase pass follows an update
	task automatic apply();
		apply_settings_strobe <= 1'b1;
		tick();
		apply_settings_strobe <= 1'b0;
	endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the pll scan chain block
`include "pscr_map.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pscr_pkg::*;

	logic               aclk, aresetn;
	logic [7:0]         s_axi_awaddr, s_axi_araddr;
	logic [31:0]        s_axi_wdata, s_axi_rdata;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic               s_axi_rvalid, s_axi_rready;
	logic               chain_shift_clock, chain_shift_enable, chain_serial_in_port;
	logic               apply_settings_strobe, reconfig_in_progress, flag_q;
	logic [9:0]         divider_clk_out;
	pscr_seg_type       loop_m_setting, loop_n_setting, loop_tail_setting;
	pscr_seg_type       seg [0:12];
	pscr_seg_type       exp_c [0:9];
	pscr_seg_type       ex_m, ex_n, ex_t;
	logic [233:0]       vec;
	int                 seed = 58583;
	int                 err_total = 0;
	int                 cmp_count = 0;
	int                 rises = 0;
	int                 half = 2;

	pscr_top #(.NUM_OUT(10)) i_pscr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chain_shift_clock, .chain_shift_enable,
		.chain_serial_in_port, .apply_settings_strobe, .reconfig_in_progress, .divider_clk_out,
		.loop_m_setting, .loop_n_setting, .loop_tail_setting);
	pscr_ctl_model i_pscr_ctl_model (.aclk, .chain_shift_clock, .chain_shift_enable,
		.chain_serial_in_port, .apply_settings_strobe);

	// 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// counts rises of the progress flag
	always @(posedge aclk) begin
		flag_q <= reconfig_in_progress;
		if (reconfig_in_progress === 1'b1 && flag_q === 1'b0)
			rises <= rises + 1;
	end

	// ============================================================
	// verdict and bus tasks
	task automatic results();
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic fail_out();
		err_total++;
		results();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (k == 50) fail_out();
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk); // lets an edge pass so rready is never assigned twice in one step
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (k == 50) fail_out();
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
	endtask

	// high and low widths of one output in aclk cycles
	task automatic meas(input int i, input pscr_seg_type s);
		int k, h, l, eh, el;
		eh = s[16] ? half : (2 * s[15:8] - s[17]) * half;
		el = s[16] ? half : (2 * s[7:0] + s[17]) * half;
		h = 0;
		l = 0;
		for (k = 0; k < 1000 && divider_clk_out[i] !== 1'b0; k++) @(posedge aclk);
		if (k == 1000) fail_out();
		for (k = 0; k < 1000 && divider_clk_out[i] !== 1'b1; k++) @(posedge aclk);
		if (k == 1000) fail_out();
		for (k = 0; k < 1000 && divider_clk_out[i] === 1'b1; k++) begin
			h++;
			@(posedge aclk);
		end
		if (k == 1000) fail_out();
		for (k = 0; k < 1000 && divider_clk_out[i] === 1'b0; k++) begin
			l++;
			@(posedge aclk);
		end
		if (k == 1000) fail_out();
		`CHK(h, eh)
		`CHK(l, el)
	endtask

	// ============================================================
	// one shift, update and completion pass with n output counters
	task automatic run_pass(input int n);
		int j, k, r0;
		for (j = 0; j < n + 3; j++) begin
			seg[j] = 18'($random(seed));
			// high and low counts 1 to 8, widened so that 7 + 1 does not wrap to a count of 256
			if (j < n) seg[j][15:0] = {4'h0, 4'(seg[j][10:8]) + 4'h1, 4'h0, 4'(seg[j][2:0]) + 4'h1};
			vec[18*j +: 18] = seg[j];
		end
		i_pscr_ctl_model.send(vec, 18 * (n + 3));
		`CHK(loop_m_setting, ex_m)
		for (j = 0; j < n; j++) exp_c[n-1-j] = seg[j];
		ex_m = seg[n];
		ex_n = seg[n+1];
		ex_t = seg[n+2];
		r0 = rises;
		i_pscr_ctl_model.apply();
		for (k = 0; k < 3000 && reconfig_in_progress !== 1'b0; k++) @(posedge aclk);
		if (k == 3000) fail_out();
		`CHK(rises, r0 + 1)
		`CHK(loop_m_setting, ex_m)
		`CHK(loop_n_setting, ex_n)
		`CHK(loop_tail_setting, ex_t)
		axr(`PSCR_STATUS_OFS, 32'h0000_0000, `PSCR_RESP_OKAY);
		axr(`PSCR_LOOPM_OFS, {14'h0000, ex_m}, `PSCR_RESP_OKAY);
		axr(`PSCR_TAIL_OFS, {14'h0000, ex_t}, `PSCR_RESP_OKAY);
		for (j = 0; j < 10; j++) begin
			axw(`PSCR_SEL_OFS, 32'(j), `PSCR_RESP_OKAY);
			axr(`PSCR_SETTING_OFS, {14'h0000, exp_c[j]}, `PSCR_RESP_OKAY);
			meas(j, exp_c[j]);
		end
	endtask

	// reset, register checks, then wide and narrow passes
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		ex_m = `PSCR_SEG_RESET;
		for (int i = 0; i < 10; i++) exp_c[i] = `PSCR_SEG_RESET;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(loop_tail_setting, `PSCR_TAIL_RESET)
		axr(`PSCR_CTRL_OFS, 32'h0000_0101, `PSCR_RESP_OKAY);
		axr(8'h1C, 32'h0000_0000, `PSCR_RESP_SLVERR);
		axw(`PSCR_STATUS_OFS, 32'h0000_0001, `PSCR_RESP_SLVERR);
		axr(`PSCR_LOOPN_OFS, {14'h0000, `PSCR_SEG_RESET}, `PSCR_RESP_OKAY);
		run_pass(10);
		// follow-up reset once the flag has fallen; settings return to their reset values
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		ex_m = `PSCR_SEG_RESET;
		for (int i = 0; i < 10; i++) exp_c[i] = `PSCR_SEG_RESET;
		@(posedge aclk);
		`CHK(loop_m_setting, ex_m)
		// byte lanes one at a time: lane 0 clears wide, lane 1 sets the half-cycle select
		s_axi_wstrb <= 4'h1;
		axw(`PSCR_CTRL_OFS, 32'h0000_0200, `PSCR_RESP_OKAY);
		axr(`PSCR_CTRL_OFS, 32'h0000_0100, `PSCR_RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		axw(`PSCR_CTRL_OFS, 32'h0000_0200, `PSCR_RESP_OKAY);
		axr(`PSCR_CTRL_OFS, 32'h0000_0200, `PSCR_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		half = 3;
		run_pass(7);
		results();
	end

	// bound on the whole run
	initial begin
		repeat (100000) @(posedge aclk);
		fail_out();
	end
endmodule
